// ==== verilog/asx_params.svh ====
// Timing and layout constants for the static memory port controller
`ifndef ASX_PARAMS_SVH
`define ASX_PARAMS_SVH
`define ASX_CLK_PS            5000
`define ASX_ADDR_W            18
`define ASX_DATA_W            16
`define ASX_LANE_W            8
`define ASX_POWERUP_US        100
`define ASX_POWERUP_CYC       ((`ASX_POWERUP_US * 1000000 + `ASX_CLK_PS - 1) / `ASX_CLK_PS)
`define ASX_ADDR_DATA_NS      10
`define ASX_OE_DATA_NS        5
`define ASX_LANE_OFF_NS       6
`define ASX_ADDR_SETUP_NS     7
`define ASX_LANE_SETUP_NS     7
`define ASX_WR_TURNOFF_NS     5
`define ASX_DATA_SETUP_NS     6
`define ASX_NS2CYC(ns)        (((ns) * 1000 + `ASX_CLK_PS - 1) / `ASX_CLK_PS)
`define ASX_MAX2(a, b)        (((a) > (b)) ? (a) : (b))
`define ASX_RD_CYC            (`ASX_MAX2(`ASX_NS2CYC(`ASX_ADDR_DATA_NS), `ASX_NS2CYC(`ASX_OE_DATA_NS)) + 1)
`define ASX_WR_CYC            (`ASX_MAX2(`ASX_MAX2(`ASX_NS2CYC(`ASX_ADDR_SETUP_NS), `ASX_NS2CYC(`ASX_LANE_SETUP_NS)), `ASX_NS2CYC(`ASX_WR_TURNOFF_NS + `ASX_DATA_SETUP_NS)))
`define ASX_TURN_CYC          `ASX_NS2CYC(`ASX_LANE_OFF_NS)
`define ASX_CNT_W             16
`endif

// ==== verilog/asx_pkg.sv ====
// Types for the static memory port controller
package asx_pkg;
  typedef enum logic [5:0] {
    ASX_POWERUP = 6'h01,
    ASX_IDLE    = 6'h02,
    ASX_RD      = 6'h04,
    ASX_WR      = 6'h08,
    ASX_WR_END  = 6'h10,
    ASX_TURN    = 6'h20
  } asx_state_e;
endpackage

// ==== verilog/asx_timer.sv ====
// Down counter for phase lengths of the memory controller
`timescale 1ns/10ps
`include "asx_params.svh"
module asx_timer
  import asx_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Control
  input  wire logic                  load,
  input  wire logic [`ASX_CNT_W-1:0] load_val,
  // Status
  output logic                       done
);
  logic [`ASX_CNT_W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!nrst) cnt_q <= '0;
    else if (load) cnt_q <= load_val;
    else if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
  end

  assign done = (cnt_q == '0);
endmodule // asx_timer

// ==== verilog/asx_ctrl.sv ====
// Host controller for an asynchronous 16-bit static memory
//
// Functional notes
// - Write only in select/strobe/lane overlap
// - Data held around the write-ending edge
// - Strobe write with OE low: turnoff+setup
// - Write strobe high during every read
// - Address valid by chip select fall
// - Wait power-up interval before first access
// - Address stable 7 ns before write end
// - Lane enable 7 ns before write end
`timescale 1ns/10ps
`include "asx_params.svh"
module asx_ctrl
  import asx_pkg::*;
#(
  parameter int unsigned POWERUP_CYC = `ASX_POWERUP_CYC
)
(
  // Clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   NRST,
  // User request
  input  wire logic                   REQ_VALID,
  output logic                        REQ_READY,
  input  wire logic                   REQ_WRITE,
  input  wire logic [`ASX_ADDR_W-1:0] REQ_ADDR,
  input  wire logic [`ASX_DATA_W-1:0] REQ_WDATA,
  input  wire logic [1:0]             REQ_LANES,
  // User read answer
  output logic                        RSP_VALID,
  output logic [`ASX_DATA_W-1:0]      RSP_RDATA,
  // Memory pins
  output logic [`ASX_ADDR_W-1:0]      MEM_ADDR,
  output logic                        MEM_CS_N,
  output logic                        MEM_OE_N,
  output logic                        MEM_WE_N,
  output logic                        MEM_LOW_LANE_ENABLE_N,
  output logic                        MEM_HIGH_LANE_ENABLE_N,
  input  wire logic [`ASX_DATA_W-1:0] MEM_DQ_IN,
  output logic [`ASX_DATA_W-1:0]      MEM_DQ_OUT,
  output logic [1:0]                  MEM_DQ_OE
);
  // ----------------------------------------------------------------
  // Phase lengths
  // ----------------------------------------------------------------
  localparam logic [`ASX_CNT_W-1:0] RD_LEN   = `ASX_CNT_W'(`ASX_RD_CYC);
  localparam logic [`ASX_CNT_W-1:0] WR_LEN   = `ASX_CNT_W'(`ASX_WR_CYC);
  localparam logic [`ASX_CNT_W-1:0] TURN_LEN = `ASX_CNT_W'(`ASX_TURN_CYC);
  localparam logic [`ASX_CNT_W-1:0] PU_LEN   = `ASX_CNT_W'(POWERUP_CYC);

  function automatic logic [1:0] lane_mask(input logic [1:0] l);
    lane_mask = (l == 2'b00) ? 2'b11 : l;
  endfunction

  asx_state_e                 state_q, state_d;
  logic [`ASX_ADDR_W-1:0]     addr_q;
  logic [`ASX_DATA_W-1:0]     wdata_q, rdata_q;
  logic [1:0]                 lanes_q;
  logic                       cs_n_q, oe_n_q, we_n_q, rsp_q;
  logic [1:0]                 ben_n_q, dq_oe_q;
  logic                       tmr_load, tmr_done;
  logic [`ASX_CNT_W-1:0]      tmr_val;
  logic                       take_req;
  logic                       pu_arm_q;
  logic [`ASX_DATA_W-1:0]     rd_merge;

  // ----------------------------------------------------------------
  // Phase timer, also counts the power-up wait
  // ----------------------------------------------------------------
  asx_timer u_timer (
    .clk      (CORE_CLK),
    .nrst     (NRST),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // ----------------------------------------------------------------
  // Request acceptance and phase sequencing
  // ----------------------------------------------------------------
  assign REQ_READY = (state_q == ASX_IDLE);
  assign take_req  = REQ_READY && REQ_VALID;

  always_comb begin
    state_d  = state_q;
    tmr_load = 1'b0;
    tmr_val  = RD_LEN;
    case (state_q)
      ASX_POWERUP: begin
        // First cycle after reset loads the wait, later cycles count it
        if (pu_arm_q) begin
          tmr_load = 1'b1;
          tmr_val  = PU_LEN;
        end else if (tmr_done) begin
          state_d = ASX_IDLE;
        end
      end
      ASX_IDLE: begin
        if (take_req) begin
          tmr_load = 1'b1;
          tmr_val  = REQ_WRITE ? WR_LEN : RD_LEN;
          state_d  = REQ_WRITE ? ASX_WR : ASX_RD;
        end
      end
      ASX_RD: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = TURN_LEN;
          state_d  = ASX_TURN;
        end
      end
      ASX_WR: begin
        if (tmr_done) state_d = ASX_WR_END;
      end
      ASX_WR_END: begin
        tmr_load = 1'b1;
        tmr_val  = TURN_LEN;
        state_d  = ASX_TURN;
      end
      ASX_TURN: begin
        if (tmr_done) state_d = ASX_IDLE;
      end
      default: state_d = ASX_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Read data merge
  // ----------------------------------------------------------------
  // Read lanes captured only where enabled
  generate
    for (genvar g = 0; g < 2; g++) begin : g_lane
      assign rd_merge[g*`ASX_LANE_W +: `ASX_LANE_W] = lanes_q[g] ?
        MEM_DQ_IN[g*`ASX_LANE_W +: `ASX_LANE_W] : rdata_q[g*`ASX_LANE_W +: `ASX_LANE_W];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    // Every reset arms the power-up wait again
    if (!NRST) begin
      state_q  <= ASX_POWERUP;
      pu_arm_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      pu_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      addr_q  <= '0;
      wdata_q <= '0;
      lanes_q <= 2'h0;
    end else if (take_req) begin
      addr_q  <= REQ_ADDR;
      wdata_q <= REQ_WDATA;
      lanes_q <= lane_mask(REQ_LANES);
    end
  end

  // ----------------------------------------------------------------
  // Pin phase: address, lanes, select and strobes start on the same edge; a write strobe rises one edge before select and lanes
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      cs_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      ben_n_q <= 2'h3;
      dq_oe_q <= 2'h0;
    end else begin
      cs_n_q  <= !(state_d == ASX_RD || state_d == ASX_WR || state_d == ASX_WR_END);
      oe_n_q  <= !(state_d == ASX_RD);
      we_n_q  <= !(state_d == ASX_WR);
      // Lanes stay low through the write end so the strobe alone ends it
      ben_n_q <= (state_d == ASX_RD || state_d == ASX_WR || state_d == ASX_WR_END) ?
                 ~(take_req ? lane_mask(REQ_LANES) : lanes_q) : 2'h3;
      dq_oe_q <= (state_d == ASX_WR || state_d == ASX_WR_END) ?
                 (take_req ? lane_mask(REQ_LANES) : lanes_q) : 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Read data sampled on the last cycle of the read phase
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      rdata_q <= '0;
      rsp_q   <= 1'b0;
    end else begin
      rsp_q <= (state_q == ASX_RD) && tmr_done;
      if ((state_q == ASX_RD) && tmr_done) rdata_q <= rd_merge;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign MEM_ADDR               = addr_q;
  assign MEM_CS_N               = cs_n_q;
  assign MEM_OE_N               = oe_n_q;
  assign MEM_WE_N               = we_n_q;
  assign MEM_LOW_LANE_ENABLE_N  = ben_n_q[0];
  assign MEM_HIGH_LANE_ENABLE_N = ben_n_q[1];
  assign MEM_DQ_OUT             = wdata_q;
  assign MEM_DQ_OE              = dq_oe_q;
  assign RSP_VALID              = rsp_q;
  assign RSP_RDATA              = rdata_q;
endmodule // asx_ctrl

// ==== tb/asx_mem_model.sv ====
// Behavioural model of the 16-bit static memory
`timescale 1ns/10ps
module asx_mem_model (
  // Strobes
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        lo_n,
  input  wire logic        hi_n,
  // Address and data
  input  wire logic [17:0] addr,
  input  wire logic [15:0] dq,
  output logic      [15:0] dq_q
);
  logic [15:0] mem [0:262143];
  wire  [15:0] word = mem[addr];
  wire         rd   = !cs_n && !oe_n && we_n;
  // Floating lane shows the inverse, never a stale value
  assign #5 dq_q[7:0]  = (rd && !lo_n) ? word[7:0] : ~word[7:0];
  assign #5 dq_q[15:8] = (rd && !hi_n) ? word[15:8] : ~word[15:8];
  always @(posedge we_n) begin
    if (!cs_n && !lo_n) mem[addr][7:0] = dq[7:0];
    if (!cs_n && !hi_n) mem[addr][15:8] = dq[15:8];
  end
endmodule // asx_mem_model

// ==== tb/asx_ctrl_chk.sv ====
// Pin protocol checker for the static memory controller
`timescale 1ns/10ps
`include "asx_params.svh"
module asx_ctrl_chk #(
  parameter int unsigned POWERUP_CYC = `ASX_POWERUP_CYC
) (
  // Clock and reset
  input wire logic                   CORE_CLK,
  input wire logic                   NRST,
  // Memory pins
  input wire logic [`ASX_ADDR_W-1:0] MEM_ADDR,
  input wire logic                   MEM_CS_N,
  input wire logic                   MEM_OE_N,
  input wire logic                   MEM_WE_N,
  input wire logic                   MEM_LOW_LANE_ENABLE_N,
  input wire logic                   MEM_HIGH_LANE_ENABLE_N,
  input wire logic [`ASX_DATA_W-1:0] MEM_DQ_OUT,
  input wire logic [1:0]             MEM_DQ_OE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  logic [31:0] up_q;
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) up_q <= 32'h0;
    else if (up_q < POWERUP_CYC) up_q <= up_q + 32'h1;
  end
  sequence s_we_low;
    !MEM_WE_N [*4] ##1 MEM_WE_N;
  endsequence
  a_read_we_high: assert property (!MEM_CS_N && !MEM_OE_N |-> MEM_WE_N)
    else $error("write strobe low during read");
  a_bus_released: assert property (!MEM_OE_N |-> MEM_DQ_OE == 2'b00)
    else $error("data driven while output enable low");
  a_addr_held: assert property (!MEM_CS_N && !$past(MEM_CS_N) |-> $stable(MEM_ADDR))
    else $error("address moved while selected");
  a_we_pulse_len: assert property ($fell(MEM_WE_N) |-> s_we_low)
    else $error("write strobe pulse too short");
  a_data_hold: assert property ($rose(MEM_WE_N) |-> MEM_DQ_OE != 2'b00 && $stable(MEM_DQ_OUT))
    else $error("write data not held at write end");
  a_we_ends_write: assert property ($rose(MEM_WE_N) |-> !MEM_CS_N)
    else $error("write not ended by strobe");
  a_lane_setup: assert property (!MEM_WE_N |=>
    $stable({MEM_LOW_LANE_ENABLE_N, MEM_HIGH_LANE_ENABLE_N}))
    else $error("lane enable changed during write");
  a_powerup_wait: assert property (!MEM_CS_N |-> up_q >= POWERUP_CYC)
    else $error("access before power-up interval");
endmodule // asx_ctrl_chk
bind asx_ctrl asx_ctrl_chk #(.POWERUP_CYC(POWERUP_CYC)) u_chk (.CORE_CLK(CORE_CLK),
  .NRST(NRST), .MEM_ADDR(MEM_ADDR), .MEM_CS_N(MEM_CS_N), .MEM_OE_N(MEM_OE_N),
  .MEM_WE_N(MEM_WE_N), .MEM_LOW_LANE_ENABLE_N(MEM_LOW_LANE_ENABLE_N),
  .MEM_HIGH_LANE_ENABLE_N(MEM_HIGH_LANE_ENABLE_N), .MEM_DQ_OUT(MEM_DQ_OUT),
  .MEM_DQ_OE(MEM_DQ_OE));

// ==== tb/async_sram_x16_port_tb.sv ====
// Self-checking bench for the static memory controller
`timescale 1ns/10ps
`include "asx_params.svh"
module async_sram_x16_port_tb;
  typedef struct packed {logic w; logic [17:0] a; logic [15:0] d; logic [1:0] l;} asx_row_s;
  logic CORE_CLK = 1'h0, NRST = 1'h0, REQ_VALID = 1'h0, REQ_WRITE = 1'h0, REQ_READY, RSP_VALID;
  logic [17:0] REQ_ADDR = 18'h0, MEM_ADDR;
  logic [15:0] REQ_WDATA = 16'h0, RSP_RDATA, MEM_DQ_IN, MEM_DQ_OUT, mem_q;
  logic [1:0] REQ_LANES = 2'h0, MEM_DQ_OE;
  logic MEM_CS_N, MEM_OE_N, MEM_WE_N, lo_n, hi_n;
  int fail_count = 0, num_checks = 0, n;
  // Reads carry the expected word in d
  asx_row_s rows [8] = '{'{1'h1, 18'h1, 16'h1234, 2'h3}, '{1'h1, 18'h1, 16'h55ab, 2'h1},
    '{1'h0, 18'h1, 16'h12ab, 2'h3}, '{1'h1, 18'h3ffff, 16'hcdef, 2'h2},
    '{1'h1, 18'h3ffff, 16'h0077, 2'h1}, '{1'h0, 18'h3ffff, 16'hcdab, 2'h2},
    '{1'h0, 18'h3ffff, 16'hcd77, 2'h1}, '{1'h0, 18'h1, 16'h12ab, 2'h0}};
  always #2.5 CORE_CLK = ~CORE_CLK;
  assign MEM_DQ_IN = {MEM_DQ_OE[1] ? MEM_DQ_OUT[15:8] : mem_q[15:8],
                      MEM_DQ_OE[0] ? MEM_DQ_OUT[7:0] : mem_q[7:0]};
  asx_ctrl #(.POWERUP_CYC(10)) dut (.CORE_CLK(CORE_CLK), .NRST(NRST), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
    .REQ_LANES(REQ_LANES), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA), .MEM_ADDR(MEM_ADDR),
    .MEM_CS_N(MEM_CS_N), .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N), .MEM_LOW_LANE_ENABLE_N(lo_n),
    .MEM_HIGH_LANE_ENABLE_N(hi_n), .MEM_DQ_IN(MEM_DQ_IN), .MEM_DQ_OUT(MEM_DQ_OUT),
    .MEM_DQ_OE(MEM_DQ_OE));
  asx_mem_model u_mem (.cs_n(MEM_CS_N), .oe_n(MEM_OE_N), .we_n(MEM_WE_N), .lo_n(lo_n),
    .hi_n(hi_n), .addr(MEM_ADDR), .dq(MEM_DQ_IN), .dq_q(mem_q));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait, one cycle a step, sampled after the edge
  task automatic wait_for(input bit rsp);
    n = 0;
    while ((rsp ? RSP_VALID : REQ_READY) !== 1'h1 && n < 200) begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end
    if (n >= 200) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic req(input asx_row_s r);
    {REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_LANES} = {1'h1, r.w, r.a, r.l};
    REQ_WDATA = r.d;
    wait_for(1'b0);
    @(posedge CORE_CLK);
    #1;
    REQ_VALID = 1'h0;
    if (!r.w) begin
      wait_for(1'b1);
      chk(n, `ASX_RD_CYC + 1);
      chk(RSP_RDATA, r.d);
    end
  endtask
  initial begin
    repeat (16) @(posedge CORE_CLK);
    #1;
    chk({MEM_CS_N, MEM_OE_N, MEM_WE_N, MEM_DQ_OE, REQ_READY}, 32'h38);
    NRST = 1'h1;
    wait_for(1'b0);
    chk(n >= 10, 1);
    $display("power-up test done");
    foreach (rows[i]) begin
      req(rows[i]);
      $display("row %0d done", i);
    end
    // Reset in mid-read, then a clean read
    {REQ_VALID, REQ_WRITE, REQ_ADDR, REQ_LANES} = {1'h1, 1'h0, 18'h1, 2'h3};
    wait_for(1'b0);
    repeat (2) @(posedge CORE_CLK);
    #1;
    {NRST, REQ_VALID} = 2'h0;
    repeat (2) @(posedge CORE_CLK);
    #1;
    chk({MEM_CS_N, MEM_OE_N, MEM_DQ_OE, RSP_VALID}, 32'h18);
    NRST = 1'h1;
    req('{1'h0, 18'h1, 16'h12ab, 2'h3});
    $display("mid-run reset test done");
    summarize();
  end
endmodule // async_sram_x16_port_tb
